//--- common/dacog_defs.svh
// register offsets, field positions, masks and reset values of the converter configuration bank
`ifndef DACOG_DEFS_SVH
`define DACOG_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define DACOG_OFS_I_OFFSET_LOW 7'h3c
`define DACOG_OFS_I_OFFSET_HIGH 7'h3d
`define DACOG_OFS_Q_OFFSET_LOW 7'h3e
`define DACOG_OFS_Q_OFFSET_HIGH 7'h3f
`define DACOG_OFS_I_FS_LOW 7'h40
`define DACOG_OFS_I_CONV_CTRL 7'h41
`define DACOG_OFS_I_AUX_MAG_LOW 7'h42
`define DACOG_OFS_I_AUX_CTRL 7'h43
`define DACOG_OFS_Q_FS_LOW 7'h44
`define DACOG_OFS_Q_CONV_CTRL 7'h45
`define DACOG_OFS_Q_AUX_MAG_LOW 7'h46
`define DACOG_OFS_Q_AUX_CTRL 7'h47
`define DACOG_OFS_AUX_ADC_RANGE 7'h48
`define DACOG_NUM_REGS 13

// ****************************************
// field positions
// ****************************************
`define DACOG_BIT_CONV_SLEEP 7
`define DACOG_BIT_AUX_SIGN 7
`define DACOG_BIT_AUX_DIR 6
`define DACOG_BIT_AUX_SLEEP 5
`define DACOG_MSB_HIGH_BITS 1
`define DACOG_MSB_RANGE_FS 6
`define DACOG_LSB_RANGE_FS 4
`define DACOG_MSB_RANGE_REF 3
`define DACOG_LSB_RANGE_REF 1
`define DACOG_BIT_RANGE_CAP 0

// ****************************************
// writable bit masks, reserved bits read zero
// ****************************************
`define DACOG_MASK_FULL 8'hff
`define DACOG_MASK_CONV_CTRL 8'h83
`define DACOG_MASK_AUX_CTRL 8'he3
`define DACOG_MASK_RANGE 8'h7f

// ****************************************
// reset values
// ****************************************
`define DACOG_RST_ZERO 8'h00
`define DACOG_RST_FS_LOW 8'hf9
`define DACOG_RST_CONV_CTRL 8'h01
`define DACOG_RST_RANGE 8'h02

`endif

//--- common/dacog_pkg.sv
// types shared by the converter configuration bank and its users
package dacog_pkg;

	// register port request from the serial control port
	typedef struct packed
	{
		logic wr_en;
		logic rd_en;
		logic [6:0] addr;
		logic [7:0] wdata;
	} dacog_req_s;

	// per-channel analog settings
	typedef struct packed
	{
		logic conv_sleep;
		logic [9:0] fullscale_code;
		logic [9:0] aux_magnitude;
		logic aux_to_negative;
		logic aux_sink;
		logic aux_sleep;
	} dacog_chan_s;

	// auxiliary converter range settings
	typedef struct packed
	{
		logic [2:0] aux_adc_range_current;
		logic [2:0] reference_current;
		logic large_capacitor;
	} dacog_range_s;

	typedef logic [7:0] dacog_byte_t;

endpackage

//--- logic/dacog_config_bank.sv
// configuration register bank with offset adders for both converter channels
`timescale 1ns/1ps
`include "dacog_defs.svh"

module dacog_config_bank
	import dacog_pkg::*;
#(
	parameter int SAMPLE_W = 16
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire dacog_req_s reg_req,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic sample_valid,
	input wire logic [SAMPLE_W-1:0] in_phase_sample,
	input wire logic [SAMPLE_W-1:0] quadrature_sample,
	output logic out_valid,
	output logic [SAMPLE_W-1:0] in_phase_out,
	output logic [SAMPLE_W-1:0] quadrature_out,
	output dacog_chan_s in_phase_cfg,
	output dacog_chan_s quadrature_cfg,
	output dacog_range_s aux_adc_range
);

	// ****************************************
	// elaboration check
	// ****************************************
	// the offsets are exactly sixteen bits wide, so other sample widths have no meaning
	if (SAMPLE_W != 16)
	begin : g_bad_width
		$error("dacog_config_bank: SAMPLE_W must be 16");
	end

	localparam logic [6:0] FIRST_OFS = `DACOG_OFS_I_OFFSET_LOW;
	localparam logic [6:0] LAST_OFS = `DACOG_OFS_AUX_ADC_RANGE;

	// ****************************************
	// register storage
	// ****************************************
	dacog_byte_t regs [`DACOG_NUM_REGS];
	dacog_byte_t next_regs [`DACOG_NUM_REGS];
	dacog_byte_t masks [`DACOG_NUM_REGS];
	logic [7:0] next_rdata;
	logic next_rvalid;
	logic hit;
	logic [3:0] idx;

	// per-register writable masks, in offset order; reset values live in the reset branch as constants
	assign masks = '{`DACOG_MASK_FULL, `DACOG_MASK_FULL, `DACOG_MASK_FULL, `DACOG_MASK_FULL,
		`DACOG_MASK_FULL, `DACOG_MASK_CONV_CTRL, `DACOG_MASK_FULL, `DACOG_MASK_AUX_CTRL,
		`DACOG_MASK_FULL, `DACOG_MASK_CONV_CTRL, `DACOG_MASK_FULL, `DACOG_MASK_AUX_CTRL,
		`DACOG_MASK_RANGE};

	// address decode: only offsets inside the bank hit
	assign hit = (reg_req.addr >= FIRST_OFS) && (reg_req.addr <= LAST_OFS);
	assign idx = 4'(reg_req.addr - FIRST_OFS);

	// write path and registered read answer; reserved bits are masked off on write
	always_comb
	begin
		for (int i = 0; i < `DACOG_NUM_REGS; i++)
		begin
			next_regs[i] = regs[i];
		end
		if (reg_req.wr_en && hit)
		begin
			next_regs[idx] = reg_req.wdata & masks[idx];
		end
		next_rvalid = reg_req.rd_en;
		next_rdata = 8'h00;
		// unmapped offsets answer zero so software never sees stale data
		if (reg_req.rd_en && hit)
		begin
			next_rdata = regs[idx];
		end
	end

	// register update, async reset to documented defaults
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			regs <= '{`DACOG_RST_ZERO, `DACOG_RST_ZERO, `DACOG_RST_ZERO, `DACOG_RST_ZERO,
				`DACOG_RST_FS_LOW, `DACOG_RST_CONV_CTRL, `DACOG_RST_ZERO, `DACOG_RST_ZERO,
				`DACOG_RST_FS_LOW, `DACOG_RST_CONV_CTRL, `DACOG_RST_ZERO, `DACOG_RST_ZERO,
				`DACOG_RST_RANGE};
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			regs <= next_regs;
			reg_rdata <= next_rdata;
			reg_rvalid <= next_rvalid;
		end
	end

	// ****************************************
	// field decode
	// ****************************************
	logic [15:0] in_phase_offset;
	logic [15:0] quadrature_offset;
	dacog_chan_s next_i_cfg;
	dacog_chan_s next_q_cfg;
	dacog_range_s next_range;

	// the two offset words, assembled from their byte halves
	assign in_phase_offset = {regs[1], regs[0]};
	assign quadrature_offset = {regs[3], regs[2]};

	// channel and auxiliary settings pulled out of the stored bytes
	always_comb
	begin
		next_i_cfg.fullscale_code = {regs[5][`DACOG_MSB_HIGH_BITS:0], regs[4]};
		next_i_cfg.conv_sleep = regs[5][`DACOG_BIT_CONV_SLEEP];
		next_i_cfg.aux_magnitude = {regs[7][`DACOG_MSB_HIGH_BITS:0], regs[6]};
		next_i_cfg.aux_to_negative = regs[7][`DACOG_BIT_AUX_SIGN];
		next_i_cfg.aux_sink = regs[7][`DACOG_BIT_AUX_DIR];
		next_i_cfg.aux_sleep = regs[7][`DACOG_BIT_AUX_SLEEP];
		next_q_cfg.fullscale_code = {regs[9][`DACOG_MSB_HIGH_BITS:0], regs[8]};
		next_q_cfg.conv_sleep = regs[9][`DACOG_BIT_CONV_SLEEP];
		next_q_cfg.aux_magnitude = {regs[11][`DACOG_MSB_HIGH_BITS:0], regs[10]};
		next_q_cfg.aux_to_negative = regs[11][`DACOG_BIT_AUX_SIGN];
		next_q_cfg.aux_sink = regs[11][`DACOG_BIT_AUX_DIR];
		next_q_cfg.aux_sleep = regs[11][`DACOG_BIT_AUX_SLEEP];
		next_range.aux_adc_range_current = regs[12][`DACOG_MSB_RANGE_FS:`DACOG_LSB_RANGE_FS];
		next_range.reference_current = regs[12][`DACOG_MSB_RANGE_REF:`DACOG_LSB_RANGE_REF];
		next_range.large_capacitor = regs[12][`DACOG_BIT_RANGE_CAP];
	end

	// settings outputs registered: one cycle after the write lands
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			in_phase_cfg <= '{1'b0, 10'h1f9, 10'h000, 1'b0, 1'b0, 1'b0};
			quadrature_cfg <= '{1'b0, 10'h1f9, 10'h000, 1'b0, 1'b0, 1'b0};
			aux_adc_range <= '{3'h0, 3'h1, 1'b0};
		end
		else
		begin
			in_phase_cfg <= next_i_cfg;
			quadrature_cfg <= next_q_cfg;
			aux_adc_range <= next_range;
		end
	end

	// ****************************************
	// offset datapath
	// ****************************************
	logic [SAMPLE_W-1:0] next_i_out;
	logic [SAMPLE_W-1:0] next_q_out;
	logic next_out_valid;

	// plain wrapping sum; a trade-off, large offsets fold over rather than clip
	always_comb
	begin
		next_out_valid = sample_valid;
		next_i_out = in_phase_out;
		next_q_out = quadrature_out;
		if (sample_valid)
		begin
			next_i_out = SAMPLE_W'(in_phase_sample + in_phase_offset);
			next_q_out = SAMPLE_W'(quadrature_sample + quadrature_offset);
		end
	end

	// one pipeline stage between the sample input and the converter
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			out_valid <= 1'b0;
			in_phase_out <= '0;
			quadrature_out <= '0;
		end
		else
		begin
			out_valid <= next_out_valid;
			in_phase_out <= next_i_out;
			quadrature_out <= next_q_out;
		end
	end

endmodule

//--- bench/dacog_config_bank_asserts.sv
// concurrent checks on the converter configuration bank ports
`timescale 1ns/1ps
module dacog_chk
	import dacog_pkg::*;
#(parameter int SAMPLE_W = 16)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire dacog_req_s reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic sample_valid,
	input wire logic [SAMPLE_W-1:0] in_phase_sample,
	input wire logic [SAMPLE_W-1:0] quadrature_sample,
	input wire logic out_valid,
	input wire logic [SAMPLE_W-1:0] in_phase_out,
	input wire logic [SAMPLE_W-1:0] quadrature_out,
	input wire dacog_chan_s in_phase_cfg,
	input wire dacog_chan_s quadrature_cfg,
	input wire dacog_range_s aux_adc_range
);
	// single clock domain, so clocking and reset are given once
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// decoded settings lag the taken write by two edges
	wire wr = reg_req.wr_en;
	wire [6:0] a = reg_req.addr;
	wire [7:0] wd = reg_req.wdata;
	property p_i_fs; wr && a == 7'h40 |-> ##2 in_phase_cfg.fullscale_code[7:0] == $past(wd, 2); endproperty
	a_i_fs: assert property (p_i_fs) else $error("i fs low");
	property p_q_fs; wr && a == 7'h44 |-> ##2 quadrature_cfg.fullscale_code[7:0] == $past(wd, 2); endproperty
	a_q_fs: assert property (p_q_fs) else $error("q fs low");
	// packed bits 23:21 are sleep and the top code bits
	property p_i_ctl; wr && a == 7'h41 |-> ##2 in_phase_cfg[23:21] == $past({wd[7], wd[1:0]}, 2); endproperty
	a_i_ctl: assert property (p_i_ctl) else $error("i ctrl");
	property p_q_ctl; wr && a == 7'h45 |-> ##2 quadrature_cfg[23:21] == $past({wd[7], wd[1:0]}, 2); endproperty
	a_q_ctl: assert property (p_q_ctl) else $error("q ctrl");
	property p_i_mag; wr && a == 7'h42 |-> ##2 in_phase_cfg.aux_magnitude[7:0] == $past(wd, 2); endproperty
	a_i_mag: assert property (p_i_mag) else $error("i aux mag");
	// packed bits 2:0 are sign, direction and aux sleep
	property p_i_aux; wr && a == 7'h43 |-> ##2 in_phase_cfg[2:0] == $past(wd[7:5], 2); endproperty
	a_i_aux: assert property (p_i_aux) else $error("i aux");
	property p_q_aux; wr && a == 7'h47 |-> ##2 quadrature_cfg[2:0] == $past(wd[7:5], 2); endproperty
	a_q_aux: assert property (p_q_aux) else $error("q aux");
	property p_rng; wr && a == 7'h48 |-> ##2 aux_adc_range.aux_adc_range_current == $past(wd[6:4], 2); endproperty
	a_rng: assert property (p_rng) else $error("range");
	c_stream: cover property (sample_valid [*3]);
	c_aux: cover property (wr && a == 7'h43 ##2 in_phase_cfg.aux_sleep);
	c_read: cover property (reg_req.rd_en ##1 reg_rvalid);
endmodule
bind dacog_config_bank dacog_chk #(.SAMPLE_W(SAMPLE_W)) u_chk (.*);

//--- bench/dacog_config_bank_test.sv
// self-checking bench for the converter configuration bank
`timescale 1ns/1ps
module dacog_config_bank_test
	import dacog_pkg::*;
;
	logic clk_sys = 1'b0, rst = 1'b1, sv = 1'b0, ov, rvalid;
	logic [15:0] si = 16'h0000, sq = 16'h0000, io, qo;
	logic [7:0] rdata, d;
	logic [7:0] m [13];
	dacog_req_s req = '0;
	dacog_chan_s ic, qc;
	dacog_range_s rg;
	int failures = 0, total_checks = 0;
	dacog_config_bank dut (.clk_sys(clk_sys), .rst(rst), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
		.sample_valid(sv), .in_phase_sample(si), .quadrature_sample(sq), .out_valid(ov), .in_phase_out(io),
		.quadrature_out(qo), .in_phase_cfg(ic), .quadrature_cfg(qc), .aux_adc_range(rg));
	// 25 MHz system clock
	initial forever #20 clk_sys = ~clk_sys;
	// an unknown result counts as a miss
	task automatic chk(input logic ok, input string s);
		total_checks++;
		if (ok !== 1'b1)
		begin
			failures++;
			$display("MISMATCH %0t %s", $time, s);
		end
	endtask
	// reserved bits read back as zero
	function automatic logic [7:0] msk(int i);
		return (i == 5 || i == 9) ? 8'h83 : (i == 7 || i == 11) ? 8'he3 : i == 12 ? 8'h7f : 8'hff;
	endfunction
	function automatic logic [7:0] rv(int i);
		return (i == 4 || i == 8) ? 8'hf9 : (i == 5 || i == 9) ? 8'h01 : i == 12 ? 8'h02 : 8'h00;
	endfunction
	// channel settings from mirrored bytes, base 0 in-phase, 4 quadrature
	function automatic dacog_chan_s cfg(int b);
		return {m[b+5][7], m[b+5][1:0], m[b+4], m[b+7][1:0], m[b+6], m[b+7][7:5]};
	endfunction
	// strobes are raised and dropped at falling edges, one edge taken each
	task automatic wr(int i, logic [7:0] v);
		@(negedge clk_sys);
		req = '{1'b1, 1'b0, 7'(i + 32'h3c), v};
		@(negedge clk_sys);
		req.wr_en = 1'b0;
	endtask
	task automatic rd(int i, logic [7:0] e);
		@(negedge clk_sys);
		req = '{1'b0, 1'b1, 7'(i + 32'h3c), 8'h00};
		@(negedge clk_sys);
		req.rd_en = 1'b0;
		chk(rvalid === 1'b1 && rdata === e, "read");
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// watchdog, roughly fifty times the expected run
	initial
	begin
		#800000;
		failures++;
		final_report;
	end
	initial
	begin
		void'($urandom(32'he0fa));
		repeat (6) @(negedge clk_sys);
		rst = 1'b0;
		for (int i = 0; i < 13; i++) m[i] = rv(i);
		for (int i = 0; i < 14; i++) rd(i, i < 13 ? m[i] : 8'h00);
		chk(ic === cfg(0) && qc === cfg(4) && rg === m[12][6:0], "reset cfg");
		$display("reset test done");
		// all ones, all zeros, then random bytes; offset 0x49 must be ignored
		for (int r = 0; r < 6; r++)
		begin
			for (int i = 0; i < 14; i++)
			begin
				d = r == 0 ? 8'hff : r == 1 ? 8'h00 : 8'($urandom);
				if (i < 13) m[i] = d & msk(i);
				wr(i, d);
			end
			for (int i = 0; i < 14; i++) rd(i, i < 13 ? m[i] : 8'h00);
			chk(ic === cfg(0) && qc === cfg(4), "cfg");
			chk(rg === m[12][6:0], "range");
		end
		$display("register test done");
		// back-to-back samples, the first in-phase one at full scale so its sum wraps
		for (int k = 0; k < 41; k++)
		begin
			@(negedge clk_sys);
			if (k > 0) chk(ov === 1'b1 && io === 16'(si + {m[1], m[0]}) && qo === 16'(sq + {m[3], m[2]}), "sum");
			si = k == 0 ? 16'hffff : k < 40 ? 16'($urandom) : si;
			sq = k < 40 ? 16'($urandom) : sq;
			sv = k < 40;
		end
		@(negedge clk_sys);
		chk(ov === 1'b0 && io === 16'(si + {m[1], m[0]}), "hold");
		$display("sample test done");
		final_report;
	end
endmodule
